/* File: rtl/tx_cmd_pkg.sv */
package tx_cmd_pkg;

	// Transmit mode codes, first byte bits 3..0
	localparam logic [3:0] MODE_OFF    = 4'h0;
	localparam logic [3:0] MODE_V22BIS = 4'h1;
	localparam logic [3:0] MODE_V22    = 4'h2;
	localparam logic [3:0] MODE_DPSK_US = 4'h3;
	localparam logic [3:0] MODE_V23    = 4'h4;
	localparam logic [3:0] MODE_V21    = 4'h5;
	localparam logic [3:0] MODE_FSK_US = 4'h6;
	localparam logic [3:0] MODE_DTMF   = 4'h7;

	// Field positions
	localparam int MODE_LSB   = 0;
	localparam int SIG_LSB    = 4;
	localparam int CHAN_BIT   = 7;
	localparam int ATT_LSB    = 0;
	localparam int SCR_BIT    = 5;
	localparam int RATE_BIT   = 7;
	localparam int KIND_BIT   = 0;
	localparam int DATA_LSB   = 1;
	localparam int TXEN_N_BIT = 7;

	// Signalling codes
	localparam logic [1:0] SIG_NONE = 2'h0;
	localparam logic [1:0] SIG_550  = 2'h1;
	localparam logic [1:0] SIG_1800 = 2'h3;

	// Attenuation
	localparam logic [4:0] ATT_MAX_FINITE = 5'h17;
	localparam logic [4:0] ATT_RESET      = 5'h1F;

	// Scrambler taps
	localparam int SCR_LEN  = 17;
	localparam int SCR_TAP1 = 14;

	// Bytes in a command word and FIFO depth
	localparam int WORD_BYTES = 3;
	localparam int FIFO_DEPTH = 4;

	typedef struct packed {
		logic [7:0] data_tone;
		logic [7:0] parameter_b;
		logic [7:0] mode_select;
	} tx_word_t;

	typedef struct packed {
		logic [3:0] mode;
		logic       is_fsk;
		logic       is_psk;
		logic       is_dtmf;
		logic [1:0] guard;
		logic       originate;
		logic       infinite_att;
		logic [4:0] atten_db;
		logic       scramble_on;
		logic       rate_600;
		logic       single_tone;
		logic       tone_low;
		logic [3:0] dtmf_code;
		logic [2:0] bits_per_baud;
		logic       tx_enable;
	} tx_cfg_t;

endpackage

/* File: rtl/word_fifo.sv */
module word_fifo #(
	parameter int WIDTH = 24,
	parameter int DEPTH = 4
) (
	input  wire logic             ref_clk,
	input  wire logic             rst,
	input  wire logic             clk_en,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [AW:0]      count;
	wire              push = in_valid && in_ready && clk_en;
	wire              pop  = out_valid && out_ready && clk_en;

	assign in_ready  = (count != (AW+1)'(DEPTH));
	assign out_valid = (count != '0);
	assign out_data  = mem[rd_ptr];

	always_ff @(posedge ref_clk) begin
		if (push)
			mem[wr_ptr] <= in_data;
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else begin
			if (push)
				wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
			if (pop)
				rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
			count <= count + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

/* File: rtl/modem_tx_command_decoder.sv */
module modem_tx_command_decoder
	import tx_cmd_pkg::*;
(
	input  wire logic       ref_clk,
	input  wire logic       rst,
	input  wire logic       clk_en,
	input  wire logic       byte_strobe,
	input  wire logic [7:0] byte_data,
	input  wire logic       word_start,
	output logic            word_ready,
	input  wire logic       baud_tick,
	input  wire logic       sample_tick,
	output tx_cfg_t         cfg,
	output logic            line_bit,
	output logic            line_bit_valid,
	output logic [3:0]      symbol,
	output logic            symbol_valid
);

	function automatic logic [2:0] bits_for(input logic [3:0] m,
		input logic r600);
		unique case (m)
			MODE_V22BIS:  bits_for = 3'h4;
			MODE_V22:     bits_for = r600 ? 3'h1 : 3'h2;
			MODE_DPSK_US: bits_for = 3'h2;
			default:      bits_for = 3'h0;
		endcase
	endfunction

	typedef enum logic [2:0] {
		ST_B0 = 3'b001,
		ST_B1 = 3'b010,
		ST_B2 = 3'b100
	} asm_state_t;

	asm_state_t       state;
	asm_state_t       next_state;
	logic [7:0]       hold_b0;
	logic [7:0]       hold_b1;
	tx_word_t         fifo_in;
	tx_word_t         cur;
	logic             fifo_out_valid;
	logic             fifo_out_ready;
	logic             fifo_in_valid;
	logic [23:0]      fifo_out_data;
	logic [2:0]       fsk_idx;
	logic [5:0]       fsk_bits;
	logic             fsk_active;
	logic [SCR_LEN:1] scr_hist;
	logic             word_loaded;
	logic             fifo_in_ready_w;

	// Byte assembly; bytes arrive low byte first
	always_comb begin
		next_state = state;
		if (byte_strobe && word_ready) begin
			unique case (state)
				ST_B0: next_state = ST_B1;
				ST_B1: next_state = ST_B2;
				ST_B2: next_state = ST_B0;
				default: next_state = ST_B0;
			endcase
		end
		if (word_start)
			next_state = ST_B0;
	end

	assign fifo_in = '{data_tone: byte_data, parameter_b: hold_b1,
		mode_select: hold_b0};
	assign fifo_in_valid = byte_strobe && (state == ST_B2) && !word_start;
	// Stall the writer on the third byte when the word queue is full
	assign word_ready = (state != ST_B2) || fifo_in_ready_w;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state   <= ST_B0;
			hold_b0 <= '0;
			hold_b1 <= '0;
		end else if (clk_en) begin
			state <= next_state;
			if (byte_strobe && state == ST_B0)
				hold_b0 <= byte_data;
			if (byte_strobe && state == ST_B1)
				hold_b1 <= byte_data;
		end
	end

	word_fifo #(.WIDTH(24), .DEPTH(FIFO_DEPTH)) u_fifo (
		.ref_clk   (ref_clk),
		.rst       (rst),
		.clk_en    (clk_en),
		.in_valid  (fifo_in_valid),
		.in_ready  (fifo_in_ready_w),
		.in_data   (fifo_in),
		.out_valid (fifo_out_valid),
		.out_ready (fifo_out_ready),
		.out_data  (fifo_out_data)
	);

	// Next word taken at each baud, but not while an FSK burst is active
	// Baud-paced exchanges
	assign fifo_out_ready = baud_tick && !fsk_active;

	// Decode of the taken word
	wire tx_word_t  nw      = tx_word_t'(fifo_out_data);
	wire [3:0]      nmode   = nw.mode_select[MODE_LSB+:4];
	wire            is_tx   = !nw.data_tone[KIND_BIT];
	wire            take    = fifo_out_valid && fifo_out_ready && clk_en;
	wire            take_tx = take && is_tx;

	// Decoded fields of the held word
	wire [3:0] cmode = cur.mode_select[MODE_LSB+:4];
	wire c_fsk  = (cmode == MODE_V23) || (cmode == MODE_V21) ||
		(cmode == MODE_FSK_US);
	wire c_psk  = (cmode == MODE_V22BIS) || (cmode == MODE_V22) ||
		(cmode == MODE_DPSK_US);
	wire c_dtmf = (cmode == MODE_DTMF);
	// Reserved codes act as modem off
	wire c_on   = c_fsk || c_psk || c_dtmf;
	// Reserved signalling code gives no guard
	wire [1:0] csig = cur.mode_select[SIG_LSB+:2];
	wire [1:0] cguard = (csig == SIG_550 || csig == SIG_1800) ?
		csig : SIG_NONE;
	wire [4:0] catt = cur.parameter_b[ATT_LSB+:5];
	wire c_inf = (catt > ATT_MAX_FINITE) || !word_loaded;
	wire c_en  = c_on && !cur.data_tone[TXEN_N_BIT] && !c_inf;
	wire c_r600 = cur.parameter_b[RATE_BIT];

	always_comb begin
		cfg = '0;
		cfg.mode          = c_on ? cmode : MODE_OFF;
		cfg.is_fsk        = c_fsk;
		cfg.is_psk        = c_psk;
		cfg.is_dtmf       = c_dtmf;
		cfg.guard         = c_dtmf ? SIG_NONE : cguard;
		cfg.originate     = !c_dtmf && cur.mode_select[CHAN_BIT];
		cfg.infinite_att  = c_inf;
		cfg.atten_db      = c_inf ? ATT_RESET : catt;
		cfg.scramble_on   = cur.parameter_b[SCR_BIT];
		cfg.rate_600      = !c_dtmf && c_r600;
		cfg.single_tone   = c_dtmf && c_r600;
		cfg.tone_low      = c_dtmf && c_r600 && cur.mode_select[CHAN_BIT];
		cfg.dtmf_code     = c_dtmf ? cur.data_tone[DATA_LSB+:4] : 4'h0;
		cfg.bits_per_baud = bits_for(cmode, c_r600);
		cfg.tx_enable     = c_en;
	end

	// Reset forces infinite attenuation via word_loaded
	// Only transmit words touch the held settings
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			cur         <= '{data_tone: 8'h80, parameter_b: 8'h1F,
				mode_select: 8'h00};
			word_loaded <= 1'b0;
		end else if (clk_en && take_tx) begin
			cur         <= nw;
			word_loaded <= 1'b1;
		end
	end

	// Symbol masked to bits used; one per baud
	wire [3:0] raw_sym = nw.data_tone[DATA_LSB+:4];
	wire [2:0] nbits   = bits_for(nmode, nw.parameter_b[RATE_BIT]);
	wire [3:0] sym_mask = (nbits == 3'h4) ? 4'hF :
		(nbits == 3'h2) ? 4'h3 : 4'h1;
	wire n_psk = (nmode == MODE_V22BIS) || (nmode == MODE_V22) ||
		(nmode == MODE_DPSK_US);
	wire n_fsk = (nmode == MODE_V23) || (nmode == MODE_V21) ||
		(nmode == MODE_FSK_US);
	wire n_en  = !nw.data_tone[TXEN_N_BIT] &&
		(nw.parameter_b[ATT_LSB+:5] <= ATT_MAX_FINITE);

	// Divide by 1 + x^-14 + x^-17
	wire scr_in  = fsk_bits[0];
	wire scr_out = scr_in ^ scr_hist[SCR_TAP1] ^ scr_hist[SCR_LEN];
	// Bypass when disabled; FSK samples scrambled only when the scramble bit is set
	wire bit_out = scr_in;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			symbol         <= 4'h0;
			symbol_valid   <= 1'b0;
			fsk_bits       <= '0;
			fsk_idx        <= 3'h0;
			fsk_active     <= 1'b0;
			line_bit       <= 1'b0;
			line_bit_valid <= 1'b0;
			scr_hist       <= '0;
		end else if (clk_en) begin
			symbol_valid   <= 1'b0;
			line_bit_valid <= 1'b0;
			if (take_tx && n_psk && n_en) begin
				symbol       <= raw_sym & sym_mask;
				symbol_valid <= 1'b1;
			end
			if (take_tx && n_fsk && n_en) begin
				fsk_bits   <= nw.data_tone[DATA_LSB+:6];
				fsk_idx    <= 3'h0;
				fsk_active <= 1'b1;
			end else if (fsk_active && sample_tick) begin
				line_bit       <= cur.parameter_b[SCR_BIT] ?
					scr_out : bit_out;
				line_bit_valid <= 1'b1;
				if (cur.parameter_b[SCR_BIT])
					scr_hist <= {scr_hist[SCR_LEN-1:1], scr_out};
				fsk_bits <= {1'b0, fsk_bits[5:1]};
				fsk_idx  <= fsk_idx + 3'h1;
				if (fsk_idx == 3'h5)
					fsk_active <= 1'b0;
			end
		end
	end

endmodule

/* File: tb/tx_cmd_props.sv */
module tx_cmd_props
	import tx_cmd_pkg::*;
(
	input wire logic       ref_clk,
	input wire logic       rst,
	input wire logic       clk_en,
	input wire logic       byte_strobe,
	input wire logic [7:0] byte_data,
	input wire logic       word_start,
	input wire logic       word_ready,
	input wire logic       baud_tick,
	input wire logic       sample_tick,
	input wire tx_cfg_t    cfg,
	input wire logic       line_bit,
	input wire logic       line_bit_valid,
	input wire logic [3:0] symbol,
	input wire logic       symbol_valid
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	sequence s_baud_seen;
		$past(baud_tick) && cfg.is_psk;
	endsequence
	sequence s_sample_seen;
		$past(sample_tick) && cfg.is_fsk;
	endsequence
	AST_RESET_ATT: assert property ($fell(rst) |->
		cfg.infinite_att && cfg.atten_db == ATT_RESET && !cfg.tx_enable)
		else $error("no infinite attenuation after reset");
	AST_INF_ATT: assert property (
		cfg.atten_db > ATT_MAX_FINITE |-> cfg.infinite_att)
		else $error("high code not infinite");
	AST_FIN_ATT: assert property (
		cfg.atten_db <= ATT_MAX_FINITE |-> !cfg.infinite_att)
		else $error("finite code gave infinite");
	AST_DTMF: assert property (
		cfg.is_dtmf == (cfg.mode == MODE_DTMF))
		else $error("tone flag wrong");
	AST_SYM: assert property (symbol_valid |-> s_baud_seen)
		else $error("symbol without baud");
	AST_FSK_BIT: assert property (line_bit_valid |-> s_sample_seen)
		else $error("line bit without sample");
	AST_GATE: assert property ((symbol_valid || line_bit_valid) |->
		cfg.tx_enable && !cfg.infinite_att)
		else $error("output while disabled");
	AST_GUARD: assert property (cfg.guard != 2'h2)
		else $error("reserved guard code");
endmodule

bind modem_tx_command_decoder tx_cmd_props props (.ref_clk(ref_clk),
	.rst(rst), .clk_en(clk_en), .byte_strobe(byte_strobe),
	.byte_data(byte_data), .word_start(word_start), .word_ready(word_ready),
	.baud_tick(baud_tick), .sample_tick(sample_tick), .cfg(cfg),
	.line_bit(line_bit), .line_bit_valid(line_bit_valid), .symbol(symbol),
	.symbol_valid(symbol_valid));

/* File: tb/ctl_proc_model.sv */
module ctl_proc_model (
	input  wire logic       ref_clk,
	input  wire logic       word_ready,
	output logic            byte_strobe,
	output logic      [7:0] byte_data
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		byte_strobe = 1'b0;
		byte_data = 8'h00;
	end
	task automatic send(input logic [7:0] m, input logic [7:0] p,
		input logic [7:0] d);
		logic [7:0] b [3];
		b = '{m & 8'hBF, p & 8'hBF, d};
		@(posedge ref_clk);
		#1;
		foreach (b[i]) begin
			byte_data = b[i];
			byte_strobe = 1'b1;
			do @(negedge ref_clk); while (word_ready !== 1'b1);
			@(posedge ref_clk);
			#1;
		end
		byte_strobe = 1'b0;
		// Idle bus inverted so no stale byte looks valid
		byte_data = ~b[2];
	endtask
endmodule

/* File: tb/modem_tx_command_decoder_test.sv */
module modem_tx_command_decoder_test
	import tx_cmd_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic        ref_clk = 1'b0;
	logic        rst = 1'b1;
	logic        baud_tick = 1'b0;
	logic        sample_tick = 1'b0;
	logic        clk_en = 1'b1;
	logic        word_start = 1'b0;
	logic        byte_strobe, word_ready, line_bit, line_bit_valid;
	logic        symbol_valid;
	logic  [7:0] byte_data;
	logic  [3:0] symbol;
	tx_cfg_t     cfg;
	logic [16:0] hist = 17'h0;
	int          failures = 0;
	int          tests_run = 0;
	always #20 ref_clk = ~ref_clk;
	modem_tx_command_decoder dut (.ref_clk(ref_clk), .rst(rst),
		.clk_en(clk_en), .byte_strobe(byte_strobe), .byte_data(byte_data),
		.word_start(word_start), .word_ready(word_ready),
		.baud_tick(baud_tick),
		.sample_tick(sample_tick), .cfg(cfg), .line_bit(line_bit),
		.line_bit_valid(line_bit_valid), .symbol(symbol),
		.symbol_valid(symbol_valid));
	ctl_proc_model proc (.ref_clk(ref_clk), .word_ready(word_ready),
		.byte_strobe(byte_strobe), .byte_data(byte_data));
	task automatic chk(input logic ok, input string msg);
		tests_run++;
		if (ok !== 1'b1) begin
			failures++;
			$display("CHECK FAILED at %0t: %s", $time, msg);
		end
	endtask
	task automatic pulse(input logic is_baud);
		@(posedge ref_clk);
		#1;
		baud_tick = is_baud;
		sample_tick = !is_baud;
		@(posedge ref_clk);
		#1;
		baud_tick = 1'b0;
		sample_tick = 1'b0;
	endtask
	task automatic t_modes;
		for (int i = 0; i < 8; i++) begin
			proc.send({4'h0, 4'(i)}, 8'h00, 8'h80);
			pulse(1'b1);
			chk(cfg.is_psk === (i inside {[1:3]}), "psk mode");
			chk(cfg.is_dtmf === (i == 7), "dtmf mode");
			chk(cfg.is_fsk === (i inside {[4:6]}), "fsk mode");
			chk(cfg.mode === 4'(i), "mode code");
		end
	endtask
	task automatic t_atten;
		logic [4:0] a [4] = '{5'h00, 5'h17, 5'h18, 5'h1F};
		logic [1:0] g [4] = '{2'h0, 2'h1, 2'h3, 2'h2};
		for (int i = 0; i < 4; i++) begin
			proc.send({1'(i), 1'b0, g[i], MODE_V22}, {3'h0, a[i]}, 8'h80);
			pulse(1'b1);
			chk(cfg.infinite_att === (i > 1), "att");
			chk(cfg.originate === 1'(i), "channel");
			chk(i > 1 || cfg.atten_db === a[i], "att code");
			chk(cfg.guard === (i == 3 ? 2'h0 : g[i]), "guard");
		end
	endtask
	task automatic t_psk;
		logic [3:0] md [4] = '{MODE_V22BIS, MODE_V22, MODE_DPSK_US, MODE_V22};
		logic [3:0] ex [4] = '{4'hA, 4'h3, 4'h0, 4'h1};
		logic [2:0] bp [4] = '{3'h4, 3'h2, 3'h2, 3'h1};
		for (int i = 0; i < 4; i++) begin
			proc.send({4'h0, md[i]}, {1'(i == 3), 7'h00},
				{3'h0, 4'hA + 4'(i), 1'b0});
			pulse(1'b1);
			chk(symbol_valid === 1'b1, "symbol valid");
			chk(symbol === ex[i], "symbol");
			chk(cfg.bits_per_baud === bp[i], "bits");
			chk(cfg.rate_600 === (i == 3), "rate");
		end
		proc.send({4'h0, MODE_V22}, 8'h00, 8'h94);
		pulse(1'b1);
		chk(symbol_valid === 1'b0, "disabled symbol");
		chk(cfg.tx_enable === 1'b0, "disabled");
		proc.send({4'h0, MODE_V21}, 8'h00, 8'h15);
		pulse(1'b1);
		chk(cfg.mode === MODE_V22, "receive word taken");
	endtask
	task automatic t_fifo;
		fork
			for (int i = 0; i < 5; i++)
				proc.send({4'h0, MODE_V22BIS}, 8'h00, 8'(2 * i + 2));
			begin
				repeat (24) @(posedge ref_clk);
				#1;
				chk(word_ready === 1'b0, "full fifo ready");
				for (int i = 0; i < 6; i++) begin
					pulse(1'b1);
					chk(symbol_valid === (i < 5), "fifo valid");
					chk(i > 4 || symbol === 4'(i + 1), "fifo order");
				end
			end
		join
	endtask
	task automatic t_fsk;
		logic [5:0] pat [4] = '{6'h2D, 6'h3F, 6'h15, 6'h2A};
		logic e;
		for (int w = 0; w < 4; w++) begin
			proc.send({4'h0, MODE_V21}, {2'h0, w > 0, 5'h00},
				{1'b0, pat[w], 1'b0});
			pulse(1'b1);
			chk(cfg.scramble_on === (w > 0), "scrambler");
			for (int b = 0; b < 6; b++) begin
				e = pat[w][b];
				if (w > 0) begin
					e = e ^ hist[13] ^ hist[16];
					hist = {hist[15:0], e};
				end
				pulse(1'b0);
				chk(line_bit_valid === 1'b1, "fsk valid");
				chk(line_bit === e, "fsk bit");
			end
		end
	endtask
	task automatic t_dtmf;
		for (int i = 0; i < 3; i++) begin
			proc.send({1'(i), 3'h0, MODE_DTMF}, {1'(i > 0), 7'h00},
				{3'h0, 4'hB - 4'(i * 6), 1'b0});
			pulse(1'b1);
			chk(cfg.single_tone === (i > 0), "tone mode");
			chk(cfg.tone_low === (i == 1), "tone half");
			chk(cfg.originate === 1'b0, "no channel in tones");
			chk(cfg.dtmf_code === 4'hB - 4'(i * 6), "tone code");
		end
	endtask
	task automatic t_ctl;
		fork
			proc.send({4'h0, MODE_V22BIS}, 8'h00, 8'h0C);
			begin
				repeat (3) @(posedge ref_clk);
				#1;
				word_start = 1'b1;
				@(posedge ref_clk);
				#1;
				word_start = 1'b0;
			end
		join
		pulse(1'b1);
		chk(symbol_valid === 1'b0, "cut word dropped");
		proc.send({4'h0, MODE_V22BIS}, 8'h00, 8'h0C);
		clk_en = 1'b0;
		pulse(1'b1);
		chk(symbol_valid === 1'b0, "frozen");
		clk_en = 1'b1;
		pulse(1'b1);
		chk(symbol_valid === 1'b1 && symbol === 4'h6, "thawed");
		rst = 1'b1;
		repeat (2) @(posedge ref_clk);
		#1;
		rst = 1'b0;
		chk(cfg.infinite_att === 1'b1, "reset att");
		chk(cfg.tx_enable === 1'b0, "reset off");
	endtask
	task automatic complete_run;
		$display("tests_run=%0d failures=%0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge ref_clk);
		#1;
		rst = 1'b0;
		chk(cfg.infinite_att === 1'b1, "reset");
		chk(cfg.atten_db === ATT_RESET, "reset code");
		t_modes();
		t_atten();
		t_psk();
		t_fifo();
		t_fsk();
		t_dtmf();
		t_ctl();
		complete_run();
	end
	initial begin
		#100000;
		failures++;
		complete_run();
	end
endmodule
